// ### rtl/wide_insn_consts.svh
// Encoding constants for the wide immediate, branch and control decoder
`ifndef WIDE_INSN_CONSTS_SVH
`define WIDE_INSN_CONSTS_SVH
`define SPACE_PREFIX 5'h1e
`define BLOCK_PREFIX 7'h74
`define HINT_FIRST 12'hf3a
`define MISC_FIRST 12'hf3b
`define RN_PC 4'hf
`define WB_SP 5'h1d
`define OP_ADD_WIDE 5'h00
`define OP_MOVE_LOW 5'h04
`define OP_SUB_WIDE 5'h0a
`define OP_MOVE_TOP 5'h0c
`define OP_SIGNED_SATURATE 5'h10
`define OP_SIGNED_SATURATE_DUAL 5'h12
`define OP_SIGNED_FIELD_EXTRACT 5'h14
`define OP_BFI 5'h16
`define OP_UNSIGNED_SATURATE 5'h18
`define OP_UNSIGNED_SATURATE_DUAL 5'h1a
`define OP_UNSIGNED_FIELD_EXTRACT 5'h1c
`define BR_COND_EXCL 3'h7
`define BR_WRITE_SPECIAL 6'h1c
`define BR_READ_SPECIAL 6'h1f
`define BR_HINT 7'h3a
`define BR_MISC 7'h3b
`define BR_UDF 7'h7f
`define BR_OP1_UDF 3'h2
`define HINT_OP1_OK 3'h0
`define HINT_NOP 8'h00
`define HINT_YIELD 8'h01
`define HINT_WFE 8'h02
`define HINT_WFI 8'h03
`define HINT_SEV 8'h04
`define HINT_SPECULATIVE_DATA_BARRIER 8'h14
`define HINT_DEBUG_TOP 4'hf
`define MISC_CLEAR_EXCLUSIVE 4'h2
`define MISC_DSB 4'h4
`define MISC_DMB 4'h5
`define MISC_ISB 4'h6
`define OPT_STORE_BYPASS_BARRIER 4'h0
`define OPT_PHYSICAL_STORE_BYPASS_BARRIER 4'h4
`define BLK_IA 2'h1
`define BLK_DB 2'h2
`define IMM_SEL_PLAIN 2'h0
`define IMM_LANE_ONE 2'h0
`define IMM_LANE_LOW 2'h1
`define IMM_LANE_HIGH 2'h2
`define ZERO_BYTE 8'h00
`define LOGICAL_MAX 4'h4
`define MODIMM_ADD 4'h8
`define MODIMM_ADC 4'ha
`define MODIMM_SBC 4'hb
`define MODIMM_SUB 4'hd
`define MODIMM_RSB 4'he
`define SHIFT_ZERO 5'h00
`endif

// ### rtl/wide_insn_pkg.sv
// Types for the wide immediate, branch and control decoder
package wide_insn_pkg;
   typedef enum logic [5:0] {
      OPC_NONE, OPC_ADD_WIDE, OPC_SUB_WIDE, OPC_PC_REL_ADDR, OPC_WIDE_MOVE_LOW, OPC_MOVE_TOP_HALF,
      OPC_SIGNED_SATURATE, OPC_UNSIGNED_SATURATE, OPC_DUAL_SIGNED_SATURATE, OPC_DUAL_UNSIGNED_SATURATE,
      OPC_SIGNED_FIELD_EXTRACT, OPC_UNSIGNED_FIELD_EXTRACT, OPC_FIELD_INSERT, OPC_FIELD_CLEAR,
      OPC_COND_BRANCH, OPC_BRANCH, OPC_BRANCH_AND_LINK, OPC_WRITE_SPECIAL_REG, OPC_READ_SPECIAL_REG,
      OPC_PERMANENT_UNDEFINED, OPC_NO_OPERATION, OPC_YIELD, OPC_WAIT_FOR_EVENT, OPC_WAIT_FOR_INTERRUPT,
      OPC_SEND_EVENT, OPC_SPECULATIVE_DATA_BARRIER, OPC_DEBUG_HINT, OPC_CLEAR_EXCLUSIVE,
      OPC_DATA_SYNC_BARRIER, OPC_DATA_MEMORY_BARRIER, OPC_INSTRUCTION_SYNC_BARRIER,
      OPC_STORE_BYPASS_BARRIER, OPC_PHYSICAL_STORE_BYPASS_BARRIER, OPC_MODIFIED_IMM_DATA_PROC,
      OPC_STORE_MULTIPLE_IA, OPC_LOAD_MULTIPLE_IA, OPC_POP, OPC_STORE_MULTIPLE_DB, OPC_PUSH,
      OPC_LOAD_MULTIPLE_DB
   } op_class_t;

   typedef struct packed {
      op_class_t op_class;
      logic undefined;
   } class_result_t;

   typedef struct packed {
      logic [15:0] first_half;
      logic [15:0] second_half;
   } insn_halves_t;

   typedef struct packed {
      op_class_t op_class;
      logic [31:0] expanded_constant;
      logic shifter_carry;
      logic carry_affected;
      logic undefined;
      logic unpredictable;
   } decoded_t;
endpackage

// ### rtl/wide_insn_imm_branch_decoder.sv
// Registered decoder for wide immediate, branch, hint and barrier encodings
`timescale 1ns/10ps
`default_nettype none
`include "wide_insn_consts.svh"

// Function
// [RULE1] Plain pattern zero-extends byte, keeps carry
// [RULE2] Pattern 01 puts byte in lanes 0, 2
// [RULE3] Pattern 10 puts byte in lanes 1, 3
// [RULE4] Pattern 11 replicates byte into all lanes
// [RULE5] Replicated pattern with zero byte is unpredictable
// [RULE6] Otherwise rotate one-prefixed seven bits, carry bit31
// [RULE7] Add/subtract wide, base PC gives address formation
// [RULE8] Opcodes 00100, 01100 are low and top moves
// [RULE9] Saturates, shifted dual opcodes decode as saturate
// [RULE10] Unshifted dual opcodes need signal-processing variant
// [RULE11] Field extract, insert, clear with base PC
// [RULE12] Unallocated plain-immediate opcodes are undefined
// [RULE13] Conditional, plain, linked branches; rest undefined
// [RULE14] Special register write and read encodings
// [RULE15] Hint and miscellaneous control sub-decoder routing
// [RULE16] Nop, yield, wait-event, wait-interrupt hints
// [RULE17] Send-event, speculative data barrier, debug hint
// [RULE18] Reserved hints execute as no operation
// [RULE19] Hint secondary opcode not 000 is undefined
// [RULE20] Clear exclusive, memory, sync, data sync barriers
// [RULE21] Store bypass barrier and its physical variant
// [RULE22] Unlisted miscellaneous control encodings are undefined
// [RULE23] Flag-setting logical carry from selector and constant
// [RULE24] Block transfer increment-after, decrement-before, push, pop
// [RULE25] Immediate assembled from i, three bits, byte
// [RULE26] Class output with undefined, unpredictable flags
module wide_insn_imm_branch_decoder
   import wide_insn_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic insn_valid_in,
   input wire insn_halves_t insn_in,
   input wire logic carry_in,
   input wire logic dsp_ext_in,
   output logic decoded_valid_out,
   output decoded_t decoded_out
);

   // ==========================================================
   // Immediate expansion
   function automatic logic [31:0] rotate_right(input logic [31:0] value, input logic [4:0] amount);
      logic [63:0] doubled;
      doubled = {value, value} >> amount;
      return doubled[31:0];
   endfunction

   function automatic logic [32:0] immediate_expand_with_carry(input logic [11:0] packed_immediate_field,
                                                               input logic carry);
      logic [7:0] byte_value;
      logic [31:0] rotated;
      byte_value = packed_immediate_field[7:0];
      rotated = rotate_right({24'h000000, 1'b1, packed_immediate_field[6:0]}, packed_immediate_field[11:7]);
      if (packed_immediate_field[11:10] == `IMM_SEL_PLAIN) begin
         case (packed_immediate_field[9:8])
            `IMM_LANE_ONE: return {carry, 24'h000000, byte_value}; // RULE1
            `IMM_LANE_LOW: return {carry, 8'h00, byte_value, 8'h00, byte_value}; // RULE2
            `IMM_LANE_HIGH: return {carry, byte_value, 8'h00, byte_value, 8'h00}; // RULE3
            default: return {carry, byte_value, byte_value, byte_value, byte_value}; // RULE4
         endcase
      end
      return {rotated[31], rotated}; // RULE6
   endfunction

   // ==========================================================
   // Plain binary immediate space
   function automatic class_result_t decode_plain(input logic [4:0] op, input logic base_is_pc,
                                                  input logic shift_zero, input logic dsp);
      class_result_t r;
      r = '{op_class: OPC_NONE, undefined: 1'b0};
      case (op)
         `OP_ADD_WIDE: r.op_class = base_is_pc ? OPC_PC_REL_ADDR : OPC_ADD_WIDE; // RULE7
         `OP_SUB_WIDE: r.op_class = base_is_pc ? OPC_PC_REL_ADDR : OPC_SUB_WIDE; // RULE7
         `OP_MOVE_LOW: r.op_class = OPC_WIDE_MOVE_LOW; // RULE8
         `OP_MOVE_TOP: r.op_class = OPC_MOVE_TOP_HALF; // RULE8
         `OP_SIGNED_SATURATE: r.op_class = OPC_SIGNED_SATURATE; // RULE9
         `OP_UNSIGNED_SATURATE: r.op_class = OPC_UNSIGNED_SATURATE; // RULE9
         `OP_SIGNED_SATURATE_DUAL: begin
            if (!shift_zero) begin
               r.op_class = OPC_SIGNED_SATURATE; // RULE9
            end else begin
               r.op_class = OPC_DUAL_SIGNED_SATURATE; // RULE10
               r.undefined = !dsp; // RULE10
            end
         end
         `OP_UNSIGNED_SATURATE_DUAL: begin
            if (!shift_zero) begin
               r.op_class = OPC_UNSIGNED_SATURATE; // RULE9
            end else begin
               r.op_class = OPC_DUAL_UNSIGNED_SATURATE; // RULE10
               r.undefined = !dsp; // RULE10
            end
         end
         `OP_SIGNED_FIELD_EXTRACT: r.op_class = OPC_SIGNED_FIELD_EXTRACT; // RULE11
         `OP_UNSIGNED_FIELD_EXTRACT: r.op_class = OPC_UNSIGNED_FIELD_EXTRACT; // RULE11
         `OP_BFI: r.op_class = base_is_pc ? OPC_FIELD_CLEAR : OPC_FIELD_INSERT; // RULE11
         default: r.undefined = 1'b1; // RULE12
      endcase
      return r;
   endfunction

   // ==========================================================
   // Hint group
   function automatic class_result_t decode_hint(input logic [2:0] secondary_opcode,
                                                 input logic [7:0] tertiary_opcode);
      class_result_t r;
      r = '{op_class: OPC_NO_OPERATION, undefined: 1'b0};
      if (secondary_opcode != `HINT_OP1_OK) begin
         r.op_class = OPC_NONE;
         r.undefined = 1'b1; // RULE19
      end else if (tertiary_opcode[7:4] == `HINT_DEBUG_TOP) begin
         r.op_class = OPC_DEBUG_HINT; // RULE17
      end else begin
         case (tertiary_opcode)
            `HINT_NOP: r.op_class = OPC_NO_OPERATION; // RULE16
            `HINT_YIELD: r.op_class = OPC_YIELD; // RULE16
            `HINT_WFE: r.op_class = OPC_WAIT_FOR_EVENT; // RULE16
            `HINT_WFI: r.op_class = OPC_WAIT_FOR_INTERRUPT; // RULE16
            `HINT_SEV: r.op_class = OPC_SEND_EVENT; // RULE17
            `HINT_SPECULATIVE_DATA_BARRIER: r.op_class = OPC_SPECULATIVE_DATA_BARRIER; // RULE17
            default: r.op_class = OPC_NO_OPERATION; // RULE18
         endcase
      end
      return r;
   endfunction

   // ==========================================================
   // Miscellaneous control group
   function automatic class_result_t decode_misc(input logic [3:0] op, input logic [3:0] option);
      class_result_t r;
      r = '{op_class: OPC_NONE, undefined: 1'b0};
      case (op)
         `MISC_CLEAR_EXCLUSIVE: r.op_class = OPC_CLEAR_EXCLUSIVE; // RULE20
         `MISC_DMB: r.op_class = OPC_DATA_MEMORY_BARRIER; // RULE20
         `MISC_ISB: r.op_class = OPC_INSTRUCTION_SYNC_BARRIER; // RULE20
         `MISC_DSB: begin
            if (option == `OPT_STORE_BYPASS_BARRIER) begin
               r.op_class = OPC_STORE_BYPASS_BARRIER; // RULE21
            end else if (option == `OPT_PHYSICAL_STORE_BYPASS_BARRIER) begin
               r.op_class = OPC_PHYSICAL_STORE_BYPASS_BARRIER; // RULE21
            end else begin
               r.op_class = OPC_DATA_SYNC_BARRIER; // RULE20
            end
         end
         default: r.undefined = 1'b1; // RULE22
      endcase
      return r;
   endfunction

   // ==========================================================
   // Branch and control space
   function automatic class_result_t decode_branch(input logic [6:0] op, input logic [2:0] secondary_opcode,
                                                   input class_result_t hint, input class_result_t misc);
      class_result_t r;
      r = '{op_class: OPC_NONE, undefined: 1'b1};
      if (secondary_opcode[0]) begin
         r.undefined = 1'b0;
         r.op_class = secondary_opcode[2] ? OPC_BRANCH_AND_LINK : OPC_BRANCH; // RULE13
      end else if (!secondary_opcode[2]) begin
         if (op[5:3] != `BR_COND_EXCL) begin
            r = '{op_class: OPC_COND_BRANCH, undefined: 1'b0}; // RULE13
         end else if (op[6:1] == `BR_WRITE_SPECIAL) begin
            r = '{op_class: OPC_WRITE_SPECIAL_REG, undefined: 1'b0}; // RULE14
         end else if (op[6:1] == `BR_READ_SPECIAL) begin
            r = '{op_class: OPC_READ_SPECIAL_REG, undefined: 1'b0}; // RULE14
         end else if (op == `BR_HINT) begin
            r = hint; // RULE15
         end else if (op == `BR_MISC) begin
            r = misc; // RULE15
         end else if (op == `BR_UDF && secondary_opcode == `BR_OP1_UDF) begin
            r = '{op_class: OPC_PERMANENT_UNDEFINED, undefined: 1'b1}; // RULE13
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Block transfer group
   function automatic class_result_t decode_block(input logic [1:0] op, input logic load,
                                                  input logic [4:0] wb_base);
      class_result_t r;
      r = '{op_class: OPC_NONE, undefined: 1'b0};
      case (op)
         `BLK_IA: begin
            if (!load) begin
               r.op_class = OPC_STORE_MULTIPLE_IA; // RULE24
            end else begin
               r.op_class = (wb_base == `WB_SP) ? OPC_POP : OPC_LOAD_MULTIPLE_IA; // RULE24
            end
         end
         `BLK_DB: begin
            if (load) begin
               r.op_class = OPC_LOAD_MULTIPLE_DB; // RULE24
            end else begin
               r.op_class = (wb_base == `WB_SP) ? OPC_PUSH : OPC_STORE_MULTIPLE_DB; // RULE24
            end
         end
         default: r.undefined = 1'b1;
      endcase
      return r;
   endfunction

   // ==========================================================
   // Field extraction
   wire logic [15:0] hw1;
   wire logic [15:0] hw2;
   wire logic [11:0] packed_immediate_field;
   wire logic [3:0] base_register_field;
   wire logic [2:0] secondary_opcode;
   wire logic [7:0] tertiary_opcode;
   wire logic [4:0] shift_bits;
   assign hw1 = insn_in.first_half;
   assign hw2 = insn_in.second_half;
   assign packed_immediate_field = {hw1[10], hw2[14:12], hw2[7:0]}; // RULE25
   assign base_register_field = hw1[3:0];
   assign secondary_opcode = hw2[14:12];
   assign tertiary_opcode = hw2[7:0];
   assign shift_bits = {hw2[14:12], hw2[7:6]};

   // ==========================================================
   // Space selection
   wire logic in_wide_space;
   wire logic is_modified_imm;
   wire logic is_plain_imm;
   wire logic is_branch;
   wire logic is_block;
   assign in_wide_space = (hw1[15:11] == `SPACE_PREFIX);
   assign is_modified_imm = in_wide_space && !hw1[9] && !hw2[15];
   assign is_plain_imm = in_wide_space && hw1[9] && !hw2[15];
   assign is_branch = in_wide_space && hw2[15];
   assign is_block = (hw1[15:9] == `BLOCK_PREFIX) && !hw1[6];

   // ==========================================================
   // Immediate and carry
   wire logic [32:0] expand_result;
   wire logic replicated_zero;
   wire logic is_logical;
   wire logic [3:0] modimm_op;
   wire logic modimm_allocated;
   assign expand_result = immediate_expand_with_carry(packed_immediate_field, carry_in);
   assign replicated_zero = (packed_immediate_field[11:10] == `IMM_SEL_PLAIN) &&
                            (packed_immediate_field[9:8] != `IMM_LANE_ONE) &&
                            (packed_immediate_field[7:0] == `ZERO_BYTE); // RULE5
   assign modimm_op = hw1[8:5];
   assign is_logical = (modimm_op <= `LOGICAL_MAX);
   assign modimm_allocated = is_logical || (modimm_op == `MODIMM_ADD) || (modimm_op == `MODIMM_ADC) ||
                             (modimm_op == `MODIMM_SBC) || (modimm_op == `MODIMM_SUB) ||
                             (modimm_op == `MODIMM_RSB);

   // ==========================================================
   // Class selection
   wire class_result_t plain_result;
   wire class_result_t hint_result;
   wire class_result_t misc_result;
   wire class_result_t branch_result;
   wire class_result_t block_result;
   wire class_result_t chosen;
   wire class_result_t modimm_result;
   wire class_result_t none_result;
   assign modimm_result = '{op_class: OPC_MODIFIED_IMM_DATA_PROC, undefined: !modimm_allocated};
   assign none_result = '{op_class: OPC_NONE, undefined: 1'b0};
   assign plain_result = decode_plain(hw1[8:4], base_register_field == `RN_PC,
                                      shift_bits == `SHIFT_ZERO, dsp_ext_in);
   assign hint_result = decode_hint(hw2[10:8], tertiary_opcode);
   assign misc_result = decode_misc(hw2[7:4], hw2[3:0]);
   assign branch_result = decode_branch(hw1[10:4], secondary_opcode, hint_result, misc_result);
   assign block_result = decode_block(hw1[8:7], hw1[4], {hw1[5], base_register_field});
   assign chosen = is_plain_imm ? plain_result :
                   is_branch ? branch_result :
                   is_block ? block_result :
                   is_modified_imm ? modimm_result :
                   none_result;

   wire decoded_t next_decoded;
   assign next_decoded.op_class = chosen.op_class; // RULE26
   assign next_decoded.expanded_constant = expand_result[31:0];
   assign next_decoded.shifter_carry = expand_result[32]; // RULE23
   assign next_decoded.carry_affected = is_modified_imm && is_logical && hw1[4] &&
                                        (packed_immediate_field[11:10] != `IMM_SEL_PLAIN); // RULE23
   assign next_decoded.undefined = chosen.undefined; // RULE26
   assign next_decoded.unpredictable = is_modified_imm && replicated_zero; // RULE5

   // ==========================================================
   // Output register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         decoded_valid_out <= 1'b0;
         decoded_out <= '0;
      end else begin
         decoded_valid_out <= insn_valid_in;
         if (insn_valid_in) begin
            decoded_out <= next_decoded;
         end
      end
   end

endmodule
`default_nettype wire

// ### tb/wide_insn_imm_branch_decoder_sva.sv
// Checker for the wide immediate, branch and control decoder
`timescale 1ns/10ps
`default_nettype none
module wide_insn_imm_branch_decoder_sva
   import wide_insn_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic insn_valid_in,
   input wire insn_halves_t insn_in,
   input wire logic carry_in,
   input wire logic dsp_ext_in,
   input wire logic decoded_valid_out,
   input wire decoded_t decoded_out
);
   // ==========================================
   // Field views and reference constants
   logic [15:0] fh;
   logic [15:0] sh;
   logic [11:0] imm;
   logic [31:0] unrot;
   logic [31:0] rot_const;
   logic [31:0] lane_const;
   logic zero_rep;
   logic mod_sp;
   logic br_sp;
   logic hint_sp;
   assign fh = insn_in.first_half;
   assign sh = insn_in.second_half;
   assign imm = {fh[10], sh[14:12], sh[7:0]};
   assign unrot = {24'h0, 1'b1, imm[6:0]};
   assign rot_const = (unrot >> imm[11:7]) | (unrot << (6'd32 - {1'b0, imm[11:7]}));
   assign lane_const = (imm[9:8] == 2'h1) ? {8'h0, imm[7:0], 8'h0, imm[7:0]} :
      (imm[9:8] == 2'h2) ? {imm[7:0], 8'h0, imm[7:0], 8'h0} : {4{imm[7:0]}};
   assign zero_rep = imm[11:10] == 2'h0 && imm[9:8] != 2'h0 && imm[7:0] == 8'h0;
   assign mod_sp = fh[15:11] == 5'h1e && !fh[9] && !sh[15];
   assign br_sp = fh[15:11] == 5'h1e && sh[15];
   assign hint_sp = br_sp && fh[10:4] == 7'h3a && !sh[14] && !sh[12];
   // ==========================================
   // Properties
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   sequence s_plain_take;
      insn_valid_in && imm[11:8] == 4'h0;
   endsequence
   a_valid_one_cycle: assert property (insn_valid_in ##1 !insn_valid_in |->
      decoded_valid_out ##1 !decoded_valid_out) else $error("decoded valid not a single pulse");
   a_idle_holds: assert property (!insn_valid_in |=> $stable(decoded_out))
      else $error("decoded word changed while idle");
   a_plain_byte: assert property (s_plain_take |=> decoded_out.expanded_constant == {24'h0, $past(imm[7:0])}
      && decoded_out.shifter_carry == $past(carry_in)) else $error("plain byte constant wrong");
   a_lane_pattern: assert property (insn_valid_in && imm[11:10] == 2'h0 && imm[9:8] != 2'h0 |=>
      decoded_out.expanded_constant == $past(lane_const) && decoded_out.shifter_carry == $past(carry_in))
      else $error("replicated byte constant wrong");
   a_rotate_carry: assert property (insn_valid_in && imm[11:10] != 2'h0 |=>
      decoded_out.expanded_constant == $past(rot_const) && decoded_out.shifter_carry == decoded_out.expanded_constant[31])
      else $error("rotated constant or carry wrong");
   a_zero_byte_unpred: assert property (insn_valid_in && mod_sp |=> decoded_out.unpredictable == $past(zero_rep))
      else $error("unpredictable flag wrong");
   a_udf_encoding: assert property (insn_valid_in && br_sp && sh[14:12] == 3'h2 && fh[10:4] == 7'h7f |=>
      decoded_out.op_class == OPC_PERMANENT_UNDEFINED && decoded_out.undefined) else $error("permanent undefined missed");
   a_hint_op1_undef: assert property (insn_valid_in && hint_sp && sh[10:8] != 3'h0 |=>
      decoded_out.undefined && decoded_out.op_class == OPC_NONE) else $error("hint secondary opcode not undefined");
endmodule
`default_nettype wire

// ### tb/fetch_stage_model.sv
// Fetch stage model that presents instruction words to the decoder
`timescale 1ns/10ps
`default_nettype none
module fetch_stage_model
   import wide_insn_pkg::*;
(
   input wire logic clk_in,
   output logic insn_valid_out,
   output insn_halves_t insn_out,
   output logic carry_out
);
   initial begin
      insn_valid_out = 1'b0;
      insn_out = insn_halves_t'(32'h0);
      carry_out = 1'b0;
   end
   // ==========================================
   // Present one word for one cycle
   task automatic issue(input logic [31:0] word, input logic carry);
      @(posedge clk_in);
      #1;
      insn_valid_out = 1'b1;
      insn_out = insn_halves_t'(word);
      carry_out = carry;
   endtask
   // Idle cycles scramble the word so a stale value is never mistaken for a new one
   task automatic idle();
      @(posedge clk_in);
      #1;
      insn_valid_out = 1'b0;
      insn_out = ~insn_out;
      carry_out = ~carry_out;
   endtask
endmodule
`default_nettype wire

// ### tb/wide_insn_imm_branch_decoder_tb_top.sv
// Testbench for the wide immediate, branch and control decoder
`timescale 1ns/10ps
`default_nettype none
module wide_insn_imm_branch_decoder_tb_top
   import wide_insn_pkg::*;
;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic dsp_ext_in = 1'b1;
   logic insn_valid_in;
   insn_halves_t insn_in;
   logic carry_in;
   logic decoded_valid_out;
   decoded_t decoded_out;
   int errors = 0;
   int n_checks = 0;
   always #4 clk_in = ~clk_in;
   fetch_stage_model fetch_stage_model_inst (.clk_in(clk_in), .insn_valid_out(insn_valid_in), .insn_out(insn_in),
      .carry_out(carry_in));
   wide_insn_imm_branch_decoder wide_insn_imm_branch_decoder_inst (.clk_in(clk_in), .rstn_in(rstn_in),
      .insn_valid_in(insn_valid_in), .insn_in(insn_in), .carry_in(carry_in), .dsp_ext_in(dsp_ext_in),
      .decoded_valid_out(decoded_valid_out), .decoded_out(decoded_out));
   // ==========================================
   // Access tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic dec(input logic [31:0] word, input logic carry);
      fetch_stage_model_inst.issue(word, carry);
      fetch_stage_model_inst.idle();
      chk("valid", 32'h1, {31'h0, decoded_valid_out});
   endtask
   task automatic cls(input logic [31:0] word, input op_class_t c, input logic u);
      dec(word, 1'b0);
      chk("class", 32'(c), 32'(decoded_out.op_class));
      chk("undefined", {31'h0, u}, {31'h0, decoded_out.undefined});
   endtask
   task automatic und(input logic [31:0] word);
      dec(word, 1'b0);
      chk("undefined", 32'h1, {31'h0, decoded_out.undefined});
   endtask
   // Flags are carry, carry affected, undefined, unpredictable
   task automatic imm(input logic [4:0] op, input logic [11:0] v, input logic c, input logic [31:0] k,
         input logic [3:0] f);
      dec({5'h1e, v[11], 1'b0, op, 4'h1, 1'b0, v[10:8], 4'h2, v[7:0]}, c);
      chk("constant", k, decoded_out.expanded_constant);
      chk("flags", {28'h0, f}, {28'h0, decoded_out.shifter_carry, decoded_out.carry_affected,
         decoded_out.undefined, decoded_out.unpredictable});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================
   // Watchdog, many times the expected run length
   initial begin
      repeat (4000) @(posedge clk_in);
      errors++;
      tally_and_finish();
   end
   // ==========================================
   // Tests
   initial begin
      repeat (12) @(posedge clk_in);
      chk("reset valid", 32'h0, {31'h0, decoded_valid_out});
      #1 rstn_in = 1'b1;
      imm(5'h10, 12'h0ab, 1'b1, 32'h000000ab, 4'h8);
      imm(5'h10, 12'h0ab, 1'b0, 32'h000000ab, 4'h0);
      imm(5'h10, 12'h1ab, 1'b1, 32'h00ab00ab, 4'h8);
      imm(5'h10, 12'h2ab, 1'b0, 32'hab00ab00, 4'h0);
      imm(5'h10, 12'h3ab, 1'b1, 32'habababab, 4'h8);
      imm(5'h10, 12'h100, 1'b0, 32'h00000000, 4'h1);
      imm(5'h10, 12'h300, 1'b0, 32'h00000000, 4'h1);
      imm(5'h10, 12'h000, 1'b1, 32'h00000000, 4'h8);
      imm(5'h10, 12'h400, 1'b0, 32'h80000000, 4'h8);
      imm(5'h10, 12'hfff, 1'b1, 32'h000001fe, 4'h0);
      imm(5'h10, 12'h4ab, 1'b1, 32'h55800000, 4'h0);
      imm(5'h01, 12'h47f, 1'b0, 32'hff000000, 4'hc);
      imm(5'h01, 12'h0ab, 1'b1, 32'h000000ab, 4'h8);
      $display("test immediate done");
      cls(32'hf2010100, OPC_ADD_WIDE, 1'b0);
      cls(32'hf20f0100, OPC_PC_REL_ADDR, 1'b0);
      cls(32'hf2a10100, OPC_SUB_WIDE, 1'b0);
      cls(32'hf2af0100, OPC_PC_REL_ADDR, 1'b0);
      cls(32'hf2410100, OPC_WIDE_MOVE_LOW, 1'b0);
      cls(32'hf2c10100, OPC_MOVE_TOP_HALF, 1'b0);
      cls(32'hf3010100, OPC_SIGNED_SATURATE, 1'b0);
      cls(32'hf3810100, OPC_UNSIGNED_SATURATE, 1'b0);
      cls(32'hf3211000, OPC_SIGNED_SATURATE, 1'b0);
      cls(32'hf3210040, OPC_SIGNED_SATURATE, 1'b0);
      cls(32'hf3a12000, OPC_UNSIGNED_SATURATE, 1'b0);
      cls(32'hf3210100, OPC_DUAL_SIGNED_SATURATE, 1'b0);
      dsp_ext_in = 1'b0;
      cls(32'hf3210100, OPC_DUAL_SIGNED_SATURATE, 1'b1);
      cls(32'hf3a10100, OPC_DUAL_UNSIGNED_SATURATE, 1'b1);
      dsp_ext_in = 1'b1;
      cls(32'hf3410100, OPC_SIGNED_FIELD_EXTRACT, 1'b0);
      cls(32'hf3c10100, OPC_UNSIGNED_FIELD_EXTRACT, 1'b0);
      cls(32'hf3610100, OPC_FIELD_INSERT, 1'b0);
      cls(32'hf36f0100, OPC_FIELD_CLEAR, 1'b0);
      und(32'hf2110100);
      $display("test plain immediate done");
      cls(32'hf0008000, OPC_COND_BRANCH, 1'b0);
      cls(32'hf400a000, OPC_COND_BRANCH, 1'b0);
      cls(32'hf780b000, OPC_BRANCH, 1'b0);
      cls(32'hf7f0f000, OPC_BRANCH_AND_LINK, 1'b0);
      cls(32'hf7f0a000, OPC_PERMANENT_UNDEFINED, 1'b1);
      cls(32'hf7808000, OPC_NONE, 1'b1);
      cls(32'hf000c000, OPC_NONE, 1'b1);
      cls(32'hf3908000, OPC_WRITE_SPECIAL_REG, 1'b0);
      cls(32'hf3f0a000, OPC_READ_SPECIAL_REG, 1'b0);
      $display("test branch done");
      cls(32'hf3af8000, OPC_NO_OPERATION, 1'b0);
      cls(32'hf3af8002, OPC_WAIT_FOR_EVENT, 1'b0);
      cls(32'hf3af8004, OPC_SEND_EVENT, 1'b0);
      cls(32'hf3af8014, OPC_SPECULATIVE_DATA_BARRIER, 1'b0);
      cls(32'hf3af80fa, OPC_DEBUG_HINT, 1'b0);
      cls(32'hf3af8005, OPC_NO_OPERATION, 1'b0);
      cls(32'hf3af8700, OPC_NONE, 1'b1);
      cls(32'hf3bf8f2f, OPC_CLEAR_EXCLUSIVE, 1'b0);
      cls(32'hf3bf8f48, OPC_DATA_SYNC_BARRIER, 1'b0);
      cls(32'hf3bf8f5f, OPC_DATA_MEMORY_BARRIER, 1'b0);
      cls(32'hf3bf8f6f, OPC_INSTRUCTION_SYNC_BARRIER, 1'b0);
      cls(32'hf3bf8f40, OPC_STORE_BYPASS_BARRIER, 1'b0);
      cls(32'hf3bf8f44, OPC_PHYSICAL_STORE_BYPASS_BARRIER, 1'b0);
      und(32'hf3bf8f7f);
      $display("test hint and control done");
      cls(32'he8814006, OPC_STORE_MULTIPLE_IA, 1'b0);
      cls(32'he8bd4006, OPC_POP, 1'b0);
      cls(32'he92d4006, OPC_PUSH, 1'b0);
      cls(32'he9114006, OPC_LOAD_MULTIPLE_DB, 1'b0);
      $display("test block transfer done");
      fetch_stage_model_inst.issue(32'hf3af8001, 1'b0);
      fetch_stage_model_inst.issue(32'hf3af8003, 1'b0);
      chk("first class", 32'(OPC_YIELD), 32'(decoded_out.op_class));
      fetch_stage_model_inst.idle();
      chk("second class", 32'(OPC_WAIT_FOR_INTERRUPT), 32'(decoded_out.op_class));
      fetch_stage_model_inst.idle();
      chk("idle valid", 32'h0, {31'h0, decoded_valid_out});
      chk("held class", 32'(OPC_WAIT_FOR_INTERRUPT), 32'(decoded_out.op_class));
      $display("test back to back done");
      rstn_in = 1'b0;
      #2;
      chk("reset class", 32'(OPC_NONE), 32'(decoded_out.op_class));
      repeat (2) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      cls(32'hf000d000, OPC_BRANCH_AND_LINK, 1'b0);
      $display("test reset recovery done");
      tally_and_finish();
   end
endmodule
bind wide_insn_imm_branch_decoder wide_insn_imm_branch_decoder_sva wide_insn_imm_branch_decoder_sva_inst (
   .clk_in(clk_in), .rstn_in(rstn_in), .insn_valid_in(insn_valid_in), .insn_in(insn_in), .carry_in(carry_in),
   .dsp_ext_in(dsp_ext_in), .decoded_valid_out(decoded_valid_out), .decoded_out(decoded_out));
`default_nettype wire
